// [spic_pkg.sv]
// Constants, types and register map of the six-source priority interrupt controller.
// How it works
// - Each source has a fixed call vector; reset vector is 0000H.
// - Nothing is accepted while the global gate is zero; sources need enable.
// - Each source takes one of four levels from low and high priority bits.
// - A running routine is preempted only by a strictly higher level.
// - Between different levels pending together, the higher level wins.
// - Equal levels are resolved by lowest vector address.
// - Each external line is level or edge triggered per its select bit.
// - Vectoring clears an external flag only in edge mode; level flag follows line.
// - Timer wrap flags are set by rollover and cleared on vectoring.
// - Serial request is OR of receive, transmit and SPI flags; none cleared.
// - Comparator flag raises its request; only software clears it.
// - Software set or clear of a flag acts like hardware set or clear, except SPI set and level-mode line flags.
// - SPI done flag is set only by hardware, cleared only by software.
// - Flags are polled in the last instruction cycle using registered values.
// - An accepted request makes the next instruction a four-cycle vectored call.
// - Vectoring is blocked by equal or higher active level, return or priority access.
// - After a return or priority access one more instruction runs first.
// - A blocked request is not remembered; each poll is new.
// - Single-interrupt response lies between 5 and 13 clock cycles.
// - Enable register at A8H, reset 00X0 0000B, gate at bit 7.
// - Low priority register at B8H, reset X0X0 0000B.
// - High priority register at B7H, reset X0X0 0000B, same bit layout.
package spic_pkg;
  localparam int NSRC = 6;
  localparam int NLVL = 4;
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_IE = 8'hA8;
  localparam logic [7:0] IDX_IPL = 8'hB8;
  localparam logic [7:0] IDX_IPH = 8'hB7;
  localparam logic [7:0] IDX_FLAGS = 8'hC0;
  localparam logic [7:0] IDX_STAT = 8'hC1;
  localparam logic [7:0] RST_IE = 8'h00;
  localparam logic [7:0] RST_IP = 8'h00;
  localparam logic [7:0] IE_MASK = 8'hDF;
  localparam logic [7:0] IP_MASK = 8'h5F;
  localparam int IE_GATE = 7;
  localparam int F_L0 = 0;
  localparam int F_T0 = 1;
  localparam int F_L1 = 2;
  localparam int F_T1 = 3;
  localparam int F_RX = 4;
  localparam int F_TX = 5;
  localparam int F_SPI = 6;
  localparam int F_CMP = 7;
  localparam int F_ES0 = 8;
  localparam int F_ES1 = 9;
  localparam int FLAG_W = 10;
  localparam logic [FLAG_W-1:0] RST_FLAGS = 10'h000;
  localparam int SRC_BIT [NSRC] = '{0, 1, 2, 3, 4, 6};
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC [NSRC] = '{16'h0003, 16'h000B, 16'h0013,
                                         16'h001B, 16'h0023, 16'h0033};
  localparam logic [15:0] VEC_SPARE = 16'h002B;
  typedef struct packed {
    logic req;
    logic [15:0] vector;
  } spic_call_t;
  typedef struct packed {
    logic timer0_wrap;
    logic timer1_wrap;
    logic uart_rx;
    logic uart_tx;
    logic spi_done;
    logic comparator;
  } spic_hwset_t;
endpackage

// [spic_ctrl.sv]
// Interrupt controller core with APB register access and CPU call request.
`timescale 1ns/1ps
module spic_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spic_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_line0_n,
  input wire logic ext_line1_n,
  input wire spic_pkg::spic_hwset_t hw_set,
  input wire logic instr_last,
  input wire logic instr_return_from_isr,
  output spic_pkg::spic_call_t cpu_call,
  output logic [spic_pkg::NLVL-1:0] level_active
);
  import spic_pkg::*;

  logic [7:0] ie;
  logic [7:0] ipl;
  logic [7:0] prio_high_bits;
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] next_flags;
  logic [1:0] pin_q;
  logic hold_off;
  logic [7:0] idx;
  logic addr_ok;
  logic access;
  logic wr_en;
  logic prio_touch;
  logic [31:0] rd_val;
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] eligible;
  logic [1:0] lvl [NSRC];
  logic found;
  logic [1:0] best_lvl;
  logic [2:0] sel_idx;
  logic accept;
  logic fall0;
  logic fall1;

  assign idx = paddr[9:2];
  assign access = psel & penable & pready;
  assign wr_en = access & pwrite & addr_ok;

  always_comb begin
    addr_ok = 1'b0;
    if (paddr[1:0] == 2'b00 && paddr[ADDR_W-1:10] == '0) begin
      case (idx)
        IDX_IE, IDX_IPL, IDX_IPH, IDX_FLAGS, IDX_STAT: begin
          addr_ok = 1'b1;
        end
        default: begin
          addr_ok = 1'b0;
        end
      endcase
    end
  end

  // Any access to enable or priority holds off vectoring until the next
  // instruction boundary has passed.
  assign prio_touch = psel & addr_ok & (idx == IDX_IE || idx == IDX_IPL || idx == IDX_IPH);

  always_comb begin
    rd_val = 32'h0000_0000;
    case (idx)
      IDX_IE: begin
        rd_val[7:0] = ie & IE_MASK;
      end
      IDX_IPL: begin
        rd_val[7:0] = ipl & IP_MASK;
      end
      IDX_IPH: begin
        rd_val[7:0] = prio_high_bits & IP_MASK;
      end
      IDX_FLAGS: begin
        rd_val[FLAG_W-1:0] = flags;
      end
      IDX_STAT: begin
        rd_val[NLVL-1:0] = level_active;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  // The slave answers in the second access cycle, so pready is a clean flop.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (psel & penable & ~pready & ~pwrite & addr_ok) begin
        prdata <= rd_val;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ie <= RST_IE;
      ipl <= RST_IP;
      prio_high_bits <= RST_IP;
    end else if (wr_en) begin
      if (idx == IDX_IE) begin
        ie <= pwdata[7:0] & IE_MASK;
      end
      if (idx == IDX_IPL) begin
        ipl <= pwdata[7:0] & IP_MASK;
      end
      if (idx == IDX_IPH) begin
        prio_high_bits <= pwdata[7:0] & IP_MASK;
      end
    end
  end

  // Serial request merges three flags; only the merged line is prioritised.
  assign req[0] = flags[F_L0];
  assign req[1] = flags[F_T0];
  assign req[2] = flags[F_L1];
  assign req[3] = flags[F_T1];
  assign req[4] = flags[F_RX] | flags[F_TX] | flags[F_SPI];
  assign req[5] = flags[F_CMP];

  for (genvar i = 0; i < NSRC; i++) begin : g_src
    assign lvl[i] = {prio_high_bits[SRC_BIT[i]], ipl[SRC_BIT[i]]};
    // A source is blocked while any marker at its level or above is set.
    assign eligible[i] = req[i] & ie[IE_GATE] & ie[SRC_BIT[i]]
                         & ((level_active >> lvl[i]) == '0);
  end

  // Strict compare keeps the lowest vector on a tie in level.
  always_comb begin
    found = 1'b0;
    best_lvl = 2'b00;
    sel_idx = 3'd0;
    for (int i = 0; i < NSRC; i++) begin
      if (eligible[i] && (!found || lvl[i] > best_lvl)) begin
        found = 1'b1;
        best_lvl = lvl[i];
        sel_idx = 3'(i);
      end
    end
  end

  // Nothing of a blocked poll is kept; the next poll starts from the flags.
  assign accept = instr_last & found & ~hold_off & ~prio_touch
                  & ~instr_return_from_isr;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_off <= 1'b0;
    end else if (instr_last) begin
      hold_off <= 1'b0;
    end else if (prio_touch) begin
      hold_off <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 2'b11;
    end else begin
      pin_q <= {ext_line1_n, ext_line0_n};
    end
  end

  assign fall0 = pin_q[0] & ~ext_line0_n;
  assign fall1 = pin_q[1] & ~ext_line1_n;

  // Order: software write, then vectoring clear, then hardware set, so a set
  // arriving in the clearing cycle is never lost.
  always_comb begin
    next_flags = flags;
    if (wr_en && idx == IDX_FLAGS) begin
      next_flags = pwdata[FLAG_W-1:0];
      next_flags[F_SPI] = flags[F_SPI] & pwdata[F_SPI];
    end
    if (accept) begin
      case (sel_idx)
        3'd0: begin
          next_flags[F_L0] = ~flags[F_ES0] & next_flags[F_L0];
        end
        3'd1: begin
          next_flags[F_T0] = 1'b0;
        end
        3'd2: begin
          next_flags[F_L1] = ~flags[F_ES1] & next_flags[F_L1];
        end
        3'd3: begin
          next_flags[F_T1] = 1'b0;
        end
        default: begin
          next_flags[F_T1] = next_flags[F_T1];
        end
      endcase
    end
    if (hw_set.timer0_wrap) begin
      next_flags[F_T0] = 1'b1;
    end
    if (hw_set.timer1_wrap) begin
      next_flags[F_T1] = 1'b1;
    end
    if (hw_set.uart_rx) begin
      next_flags[F_RX] = 1'b1;
    end
    if (hw_set.uart_tx) begin
      next_flags[F_TX] = 1'b1;
    end
    if (hw_set.spi_done) begin
      next_flags[F_SPI] = 1'b1;
    end
    if (hw_set.comparator) begin
      next_flags[F_CMP] = 1'b1;
    end
    if (flags[F_ES0]) begin
      next_flags[F_L0] = next_flags[F_L0] | fall0;
    end else begin
      next_flags[F_L0] = ~ext_line0_n;
    end
    if (flags[F_ES1]) begin
      next_flags[F_L1] = next_flags[F_L1] | fall1;
    end else begin
      next_flags[F_L1] = ~ext_line1_n;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  // The call request is issued in the first cycle of the next instruction;
  // the sequencer spends four cycles on the call itself.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_call.req <= 1'b0;
      cpu_call.vector <= VEC_RESET;
    end else begin
      cpu_call.req <= accept;
      if (accept) begin
        cpu_call.vector <= VEC[sel_idx];
      end
    end
  end

  // A return always closes the highest level that is open.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_active <= '0;
    end else if (accept) begin
      level_active[best_lvl] <= 1'b1;
    end else if (instr_return_from_isr && instr_last) begin
      if (level_active[3]) begin
        level_active[3] <= 1'b0;
      end else if (level_active[2]) begin
        level_active[2] <= 1'b0;
      end else if (level_active[1]) begin
        level_active[1] <= 1'b0;
      end else begin
        level_active[0] <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_gate_off_call: assert property (cpu_call.req |-> $past(ie[IE_GATE]))
    else $error("call issued with global gate low");
  a_poll_at_end: assert property (cpu_call.req |-> $past(instr_last))
    else $error("call not tied to last instruction cycle");
  a_return_from_isr_holds: assert property (instr_return_from_isr && instr_last |=> !cpu_call.req)
    else $error("call right after return");
  a_top_level_kept: assert property (level_active[3] && !instr_return_from_isr |=> !cpu_call.req)
    else $error("highest level routine preempted");
  a_marker_on_call: assert property (cpu_call.req |-> level_active != '0)
    else $error("call without in-progress marker");
  a_timer_cleared: assert property (accept && sel_idx == 3'd1 && !hw_set.timer0_wrap
    |=> !flags[F_T0])
    else $error("timer flag not cleared on vectoring");
  a_serial_kept: assert property (accept && sel_idx == 3'd4 && !wr_en
    && !hw_set.uart_rx && !hw_set.uart_tx
    |=> flags[F_RX] == $past(flags[F_RX]) && flags[F_TX] == $past(flags[F_TX]))
    else $error("serial flag changed on vectoring");
  a_spi_no_sw_set: assert property (wr_en && idx == IDX_FLAGS && !flags[F_SPI]
    && !hw_set.spi_done |=> !flags[F_SPI])
    else $error("software set SPI flag");
  a_level_follows: assert property (!flags[F_ES0] |=> flags[F_L0] == !$past(ext_line0_n))
    else $error("level flag not following line");

  c_nested: cover property (accept && level_active != '0);
  c_tie: cover property (instr_last && eligible[0] && eligible[2] && lvl[0] == lvl[2]);
  c_blocked: cover property (instr_last && found && prio_touch);
endmodule

// [spic_cpu_model.sv]
// Behavioural CPU sequencer that ends instructions and runs the vectored call.
`timescale 1ns/1ps
module spic_cpu_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] instr_len,
  input wire logic return_from_isr_next,
  input wire logic call_seen,
  output logic instr_last,
  output logic instr_return_from_isr
);
  logic [2:0] cnt;
  assign instr_last = (cnt == 3'h1);
  assign instr_return_from_isr = instr_last & return_from_isr_next;
  // The call cycle that shows the request counts as the first of the four.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 3'h1;
    end else if (call_seen) begin
      cnt <= 3'h3;
    end else if (instr_last) begin
      cnt <= instr_len;
    end else begin
      cnt <= cnt - 3'h1;
    end
  end
endmodule

// [testbench.sv]
// Self-checking bench for the six-source priority interrupt controller.
`timescale 1ns/1ps
module testbench;
  import spic_pkg::*;
  logic core_clk, rst_n, psel, penable, pwrite, l0_n, l1_n, return_from_isr_next, il, ir, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, er;
  spic_hwset_t hw_set;
  spic_call_t cpu_call;
  logic [NLVL-1:0] level_active;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  spic_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_line0_n(l0_n), .ext_line1_n(l1_n), .hw_set(hw_set),
    .instr_last(il), .instr_return_from_isr(ir), .cpu_call(cpu_call), .level_active(level_active));
  spic_cpu_model u_cpu (.core_clk(core_clk), .rst_n(rst_n), .instr_len(3'h3),
    .return_from_isr_next(return_from_isr_next), .call_seen(cpu_call.req), .instr_last(il), .instr_return_from_isr(ir));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Registered outputs are read in the active region, so the edge sees the old cycle.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    er = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
    chk(er, e);
  endtask
  task automatic pulse(input logic [5:0] s);
    hw_set <= spic_hwset_t'(s);
    @(posedge core_clk);
    hw_set <= '0;
  endtask
  task automatic wait_call(input logic [15:0] v, input logic take);
    int n;
    n = 0;
    while (cpu_call.req !== 1'b1 && n < 16) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, n < 16}, {31'h0, take});
    if (take) begin
      chk({16'h0, cpu_call.vector}, {16'h0, v});
      chk({31'h0, n + 4 < 13}, 32'h1);
      chk({31'h0, n + 4 > 5}, 32'h1);
      // Let the rest of the call pass, so that a following return is not
      // ended by the call instruction itself.
      repeat (3) @(posedge core_clk);
    end
  endtask
  task automatic return_from_isr();
    return_from_isr_next <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (il !== 1'b1);
    return_from_isr_next <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic t_reset();
    rchk(IDX_IE, {24'h0, RST_IE}, 32'h0);
    rchk(IDX_IPL, {24'h0, RST_IP}, 32'h0);
    rchk(IDX_IPH, {24'h0, RST_IP}, 32'h0);
    rchk(8'h10, 32'h0, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_gate();
    apb(1'b1, IDX_IE, 32'h0000_0002);
    pulse(6'h20);
    wait_call(16'h0, 1'b0);
    apb(1'b1, IDX_IE, 32'h0000_0082);
    wait_call(VEC[1], 1'b1);
    rchk(IDX_FLAGS, 32'h0, 32'h0);
    chk({28'h0, level_active}, 32'h1);
    return_from_isr();
    chk({28'h0, level_active}, 32'h0);
    $display("test gate done");
  endtask
  task automatic t_prio();
    apb(1'b1, IDX_IE, 32'h0000_00CA);
    apb(1'b1, IDX_IPH, 32'h0000_004A);
    apb(1'b1, IDX_IPL, 32'h0000_0040);
    pulse(6'h31);
    wait_call(VEC[5], 1'b1);
    chk({28'h0, level_active}, 32'h8);
    wait_call(16'h0, 1'b0);
    apb(1'b1, IDX_FLAGS, 32'h0000_000A);
    return_from_isr();
    wait_call(VEC[1], 1'b1);
    wait_call(16'h0, 1'b0);
    return_from_isr();
    wait_call(VEC[3], 1'b1);
    return_from_isr();
    $display("test priority done");
  endtask
  task automatic t_serial();
    apb(1'b1, IDX_IE, 32'h0000_0090);
    pulse(6'h04);
    wait_call(VEC[4], 1'b1);
    rchk(IDX_FLAGS, 32'h0000_0020, 32'h0);
    apb(1'b1, IDX_FLAGS, 32'h0000_0040);
    rchk(IDX_FLAGS, 32'h0, 32'h0);
    return_from_isr();
    wait_call(16'h0, 1'b0);
    $display("test serial done");
  endtask
  task automatic t_line();
    apb(1'b1, IDX_IE, 32'h0000_0081);
    apb(1'b1, IDX_FLAGS, 32'h0000_0100);
    l0_n <= 1'b0;
    wait_call(VEC[0], 1'b1);
    rchk(IDX_FLAGS, 32'h0000_0100, 32'h0);
    return_from_isr();
    wait_call(16'h0, 1'b0);
    l0_n <= 1'b1;
    apb(1'b1, IDX_FLAGS, 32'h0000_0000);
    l0_n <= 1'b0;
    wait_call(VEC[0], 1'b1);
    rchk(IDX_FLAGS, 32'h0000_0001, 32'h0);
    l0_n <= 1'b1;
    return_from_isr();
    apb(1'b1, IDX_IE, 32'h0000_0084);
    apb(1'b1, IDX_FLAGS, 32'h0000_0200);
    l1_n <= 1'b0;
    wait_call(VEC[2], 1'b1);
    rchk(IDX_FLAGS, 32'h0000_0200, 32'h0);
    l1_n <= 1'b1;
    return_from_isr();
    $display("test line done");
  endtask
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    l0_n = 1'b1;
    l1_n = 1'b1;
    return_from_isr_next = 1'b0;
    hw_set = '0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_gate();
    t_prio();
    t_serial();
    t_line();
    end_of_test();
  end
endmodule
